// file: tsi_map.svh
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH

// Upper four bits of the target address; the low three come from straps
`define TSI_ADDR_FIXED     4'h9
`define TSI_BITS_PER_BYTE  4'h8
`define TSI_BIT_FIRST      4'h1
`define TSI_BIT_NONE       4'h0

`define TSI_PTR_AMB        2'h0
`define TSI_PTR_CFG        2'h1
`define TSI_PTR_HYST       2'h2
`define TSI_PTR_LIMIT      2'h3

// Write byte index: pointer, high data byte, low data byte, then any surplus bytes
`define TSI_WIDX_PTR       2'h0
`define TSI_WIDX_HI        2'h1
`define TSI_WIDX_LO        2'h2
`define TSI_WIDX_LAST      2'h3

`define TSI_RST_PTR        2'h0
`define TSI_RST_CFG        8'h00
`define TSI_RST_HYST       16'h0000
`define TSI_RST_LIMIT      16'h0000
`define TSI_RST_AMB        16'h0000
// Only the half-degree bit survives in the low byte of the limit registers
`define TSI_LIMIT_LO_MASK  8'h80

`define TSI_FIFO_WIDTH     16
`define TSI_FIFO_DEPTH     16

`endif

// file: tsi_pkg.sv
package tsi_pkg;

	typedef enum logic [2:0] {
		TSI_IDLE     = 3'b000,
		TSI_ADDR     = 3'b001,
		TSI_ADDR_ACK = 3'b010,
		TSI_WR_BYTE  = 3'b011,
		TSI_WR_ACK   = 3'b100,
		TSI_RD_BYTE  = 3'b101,
		TSI_RD_ACK   = 3'b110
	} tsi_state_e;

	typedef logic [1:0] tsi_ptr_t;

endpackage : tsi_pkg

// file: tsi_stream_if.sv
`timescale 1ns/1ps
interface tsi_stream_if #(
	parameter int WIDTH = 16
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : tsi_stream_if

// file: tsi_sync.sv
`timescale 1ns/1ps
module tsi_sync #(
	parameter int             WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	// First stage is read by the second stage only
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta     <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : tsi_sync

// file: tsi_fifo.sv
`timescale 1ns/1ps
module tsi_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic   clk,
	input  wire logic   reset,
	tsi_stream_if.snk   wr,
	tsi_stream_if.src   rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic [AW:0]      fill;
	wire              do_push;
	wire              do_pop;
	wire              full;
	wire              empty;

	assign fill     = wr_ptr - rd_ptr;
	assign full     = (fill == (AW+1)'(DEPTH));
	assign empty    = (fill == '0);
	assign do_push  = wr.valid & ~full;
	assign do_pop   = rd.ready & ~empty;
	assign wr.ready = ~full;
	assign rd.valid = ~empty;
	assign rd.data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr[AW-1:0]] <= wr.data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= wr_ptr + (AW+1)'(do_push);
			rd_ptr <= rd_ptr + (AW+1)'(do_pop);
		end
	end
endmodule : tsi_fifo

// file: tsi_i2c_slave.sv
`timescale 1ns/1ps
`include "tsi_map.svh"
module tsi_i2c_slave #(
	parameter int FIFO_WIDTH = `TSI_FIFO_WIDTH,
	parameter int FIFO_DEPTH = `TSI_FIFO_DEPTH
) (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic                   scl_in,
	input  wire logic                   sda_in,
	output logic                        sda_out,
	output logic                        sda_oe_n,
	input  wire logic                   addr_strap_bit2,
	input  wire logic                   addr_strap_bit1,
	input  wire logic                   addr_strap_bit0,
	input  wire logic                   temp_valid,
	input  wire logic [FIFO_WIDTH-1:0]  temp_data,
	output logic                        temp_ready,
	output tsi_pkg::tsi_ptr_t           reg_ptr,
	output logic [7:0]                  config_reg,
	output logic [15:0]                 hysteresis_limit_reg,
	output logic [15:0]                 limit_set_reg,
	output logic [15:0]                 ambient_reg,
	output logic                        bus_busy,
	output logic                        end_of_read_marker,
	output logic                        reg_written
);
	import tsi_pkg::*;

	function automatic logic [7:0] tsi_pick(input logic [15:0] word, input logic hi);
		tsi_pick = hi ? word[15:8] : word[7:0];
	endfunction : tsi_pick

	tsi_stream_if #(.WIDTH(FIFO_WIDTH)) fifo_in ();
	tsi_stream_if #(.WIDTH(FIFO_WIDTH)) fifo_out ();

	assign fifo_in.valid = temp_valid;
	assign fifo_in.data  = temp_data;
	assign temp_ready    = fifo_in.ready;

	tsi_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk   (clk),
		.reset (reset),
		.wr    (fifo_in),
		.rd    (fifo_out)
	);

	// Bus lines and straps come from outside the clock domain
	logic [4:0] pins_s;

	tsi_sync #(
		.WIDTH   (5),
		.RST_VAL (5'h1F)
	) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in ({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, scl_in, sda_in}),
		.sync_out (pins_s)
	);

	wire        scl_s = pins_s[1];
	wire        sda_s = pins_s[0];
	wire [2:0]  strap = pins_s[4:2];

	logic       scl_q;
	logic       sda_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	wire scl_rise  = scl_s & ~scl_q;
	wire scl_fall  = ~scl_s & scl_q;
	// Data moving while the clock stays high is never a data bit
	wire start_det = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;

	tsi_state_e state;
	tsi_state_e next_state;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic [7:0] tx_byte;
	logic [7:0] next_tx_byte;
	logic       next_sda_oe_n;
	logic       rw_read;
	logic       next_rw_read;
	logic       rd_hi;
	logic       next_rd_hi;
	logic       nak_seen;
	logic       next_nak_seen;
	logic [1:0] wr_idx;
	logic [1:0] next_wr_idx;
	logic [7:0] hi_stage;
	logic [7:0] next_hi_stage;
	tsi_ptr_t   next_reg_ptr;
	logic [7:0] next_config_reg;
	logic [15:0] next_hyst;
	logic [15:0] next_limit;
	logic       next_busy;
	logic       next_eor;
	logic       next_written;

	wire        byte_done = (bit_cnt == `TSI_BITS_PER_BYTE);
	wire [6:0]  my_addr   = {`TSI_ADDR_FIXED, strap};
	wire        addr_hit  = (shift[7:1] == my_addr);
	wire        ptr_cfg   = (reg_ptr == `TSI_PTR_CFG);
	wire [15:0] sel_word  = (reg_ptr == `TSI_PTR_AMB)  ? ambient_reg :
	                        ptr_cfg                    ? {config_reg, config_reg} :
	                        (reg_ptr == `TSI_PTR_HYST) ? hysteresis_limit_reg :
	                                                     limit_set_reg;
	wire [7:0]  first_byte = tsi_pick(sel_word, 1'b1);
	wire [7:0]  again_byte = tsi_pick(sel_word, ptr_cfg | ~rd_hi);
	wire        reading    = (state == TSI_RD_BYTE) | (state == TSI_RD_ACK);

	// Ambient snapshot is frozen while a read is shifting out; a pop on the cycle the high byte is taken can still tear
	assign fifo_out.ready = ~reading;
	// Open drain: only ever pull low, the enable decides
	assign sda_out = 1'b0;

	always_comb begin
		next_state      = state;
		next_bit_cnt    = bit_cnt;
		next_shift      = shift;
		next_tx_byte    = tx_byte;
		next_sda_oe_n   = sda_oe_n;
		next_rw_read    = rw_read;
		next_rd_hi      = rd_hi;
		next_nak_seen   = nak_seen;
		next_wr_idx     = wr_idx;
		next_hi_stage   = hi_stage;
		next_reg_ptr    = reg_ptr;
		next_config_reg = config_reg;
		next_hyst       = hysteresis_limit_reg;
		next_limit      = limit_set_reg;
		next_busy       = bus_busy;
		next_eor        = 1'b0;
		next_written    = 1'b0;
		if (start_det) begin
			// Repeated start wipes whatever was in progress
			next_state    = TSI_ADDR;
			next_bit_cnt  = `TSI_BIT_NONE;
			next_sda_oe_n = 1'b1;
			next_busy     = 1'b1;
		end else if (stop_det) begin
			next_state    = TSI_IDLE;
			next_sda_oe_n = 1'b1;
			next_busy     = 1'b0;
		end else begin
			unique case (state)
				TSI_IDLE: begin
					next_sda_oe_n = 1'b1;
				end
				TSI_ADDR: begin
					if (scl_rise && !byte_done) begin
						next_shift   = {shift[6:0], sda_s};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && byte_done) begin
						if (addr_hit) begin
							next_sda_oe_n = 1'b0;
							next_rw_read  = shift[0];
							next_state    = TSI_ADDR_ACK;
						end else begin
							next_state    = TSI_IDLE;
						end
					end
				end
				TSI_ADDR_ACK: begin
					// Acknowledge released only after the ninth clock falls
					if (scl_fall) begin
						if (rw_read) begin
							next_state    = TSI_RD_BYTE;
							next_sda_oe_n = first_byte[7];
							next_tx_byte  = {first_byte[6:0], 1'b1};
							next_bit_cnt  = `TSI_BIT_FIRST;
							next_rd_hi    = 1'b1;
						end else begin
							next_state    = TSI_WR_BYTE;
							next_sda_oe_n = 1'b1;
							next_bit_cnt  = `TSI_BIT_NONE;
							next_wr_idx   = `TSI_WIDX_PTR;
						end
					end
				end
				TSI_WR_BYTE: begin
					if (scl_rise && !byte_done) begin
						next_shift   = {shift[6:0], sda_s};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && byte_done) begin
						next_sda_oe_n = 1'b0;
						next_state    = TSI_WR_ACK;
						unique case (wr_idx)
							`TSI_WIDX_PTR: begin
								next_reg_ptr = shift[1:0];
							end
							`TSI_WIDX_HI: begin
								if (ptr_cfg) begin
									next_config_reg = shift;
									next_written    = 1'b1;
								end else begin
									next_hi_stage   = shift;
								end
							end
							`TSI_WIDX_LO: begin
								// Ambient stays read-only; written bytes are dropped
								if (reg_ptr == `TSI_PTR_HYST) begin
									next_hyst    = {hi_stage, shift & `TSI_LIMIT_LO_MASK};
									next_written = 1'b1;
								end else if (reg_ptr == `TSI_PTR_LIMIT) begin
									next_limit   = {hi_stage, shift & `TSI_LIMIT_LO_MASK};
									next_written = 1'b1;
								end
							end
							`TSI_WIDX_LAST: begin
								// Surplus bytes are acknowledged and ignored
								next_written = 1'b0;
							end
						endcase
					end
				end
				TSI_WR_ACK: begin
					if (scl_fall) begin
						next_sda_oe_n = 1'b1;
						next_bit_cnt  = `TSI_BIT_NONE;
						next_state    = TSI_WR_BYTE;
						if (wr_idx != `TSI_WIDX_LAST) begin
							next_wr_idx = wr_idx + 2'h1;
						end
					end
				end
				TSI_RD_BYTE: begin
					// New bit placed just after the fall, well inside the low phase
					if (scl_fall) begin
						if (byte_done) begin
							next_sda_oe_n = 1'b1;
							next_state    = TSI_RD_ACK;
						end else begin
							next_sda_oe_n = tx_byte[7];
							next_tx_byte  = {tx_byte[6:0], 1'b1};
							next_bit_cnt  = bit_cnt + 4'h1;
						end
					end
				end
				TSI_RD_ACK: begin
					if (scl_rise) begin
						next_nak_seen = sda_s;
					end else if (scl_fall) begin
						if (nak_seen) begin
							// Line stays released so the master can stop
							next_state    = TSI_IDLE;
							next_sda_oe_n = 1'b1;
							next_eor      = 1'b1;
						end else begin
							// Two-byte registers alternate halves, never the next register
							next_state    = TSI_RD_BYTE;
							next_sda_oe_n = again_byte[7];
							next_tx_byte  = {again_byte[6:0], 1'b1};
							next_bit_cnt  = `TSI_BIT_FIRST;
							next_rd_hi    = ptr_cfg | ~rd_hi;
						end
					end
				end
				default: begin
					next_state    = TSI_IDLE;
					next_sda_oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state    <= TSI_IDLE;
			bit_cnt  <= `TSI_BIT_NONE;
			shift    <= '0;
			tx_byte  <= '0;
			sda_oe_n <= 1'b1;
			rw_read  <= 1'b0;
			rd_hi    <= 1'b1;
			nak_seen <= 1'b0;
			wr_idx   <= `TSI_WIDX_PTR;
			hi_stage <= '0;
		end else begin
			state    <= next_state;
			bit_cnt  <= next_bit_cnt;
			shift    <= next_shift;
			tx_byte  <= next_tx_byte;
			sda_oe_n <= next_sda_oe_n;
			rw_read  <= next_rw_read;
			rd_hi    <= next_rd_hi;
			nak_seen <= next_nak_seen;
			wr_idx   <= next_wr_idx;
			hi_stage <= next_hi_stage;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reg_ptr              <= `TSI_RST_PTR;
			config_reg           <= `TSI_RST_CFG;
			hysteresis_limit_reg <= `TSI_RST_HYST;
			limit_set_reg        <= `TSI_RST_LIMIT;
			bus_busy             <= 1'b0;
			end_of_read_marker   <= 1'b0;
			reg_written          <= 1'b0;
		end else begin
			reg_ptr              <= next_reg_ptr;
			config_reg           <= next_config_reg;
			hysteresis_limit_reg <= next_hyst;
			limit_set_reg        <= next_limit;
			bus_busy             <= next_busy;
			end_of_read_marker   <= next_eor;
			reg_written          <= next_written;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ambient_reg <= `TSI_RST_AMB;
		end else if (fifo_out.valid && fifo_out.ready) begin
			ambient_reg <= fifo_out.data[15:0];
		end
	end
endmodule : tsi_i2c_slave

// file: tsi_i2c_checker.sv
`timescale 1ns/1ps
module tsi_i2c_checker (
	input wire logic              clk,
	input wire logic              reset,
	input wire logic              scl_in,
	input wire logic              sda_in,
	input wire logic              sda_out,
	input wire logic              sda_oe_n,
	input wire logic              bus_busy,
	input wire logic              end_of_read_marker,
	input wire tsi_pkg::tsi_ptr_t reg_ptr
);
	import tsi_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence start_seen;
		$fell(sda_in) && scl_in;
	endsequence
	sequence restart_seen;
		$fell(sda_in) && scl_in && bus_busy;
	endsequence
	sequence stop_seen;
		$rose(sda_in) && scl_in && bus_busy;
	endsequence
	start_busy_a: assert property (start_seen |-> ##[1:5] bus_busy)
		else $error("start not seen");
	stop_idle_a: assert property (stop_seen |-> ##[1:5] !bus_busy)
		else $error("stop not seen");
	restart_hold_a: assert property (restart_seen |-> bus_busy [*6])
		else $error("restart dropped busy");
	idle_release_a: assert property ((!bus_busy) [*3] |-> sda_oe_n)
		else $error("data driven on idle bus");
	target_only_a: assert property ((sda_out == 1'b0) && (sda_oe_n || bus_busy))
		else $error("data pulled outside a transfer");
	change_low_a: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("data changed while clock high");
	ack_hold_a: assert property ($fell(sda_oe_n) |-> (!sda_oe_n) [*8])
		else $error("low level too short");
	nak_release_a: assert property (end_of_read_marker |-> sda_oe_n [*8])
		else $error("data driven after master nak");
	ptr_hold_a: assert property ($changed(reg_ptr) |-> bus_busy)
		else $error("pointer changed outside transfer");
endmodule : tsi_i2c_checker

bind tsi_i2c_slave tsi_i2c_checker chk (.clk(clk), .reset(reset), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bus_busy(bus_busy),
	.end_of_read_marker(end_of_read_marker), .reg_ptr(reg_ptr));

// file: tsi_bus_master.sv
`timescale 1ns/1ps
module tsi_bus_master #(
	// A quarter of the 160 ns link clock period
	parameter int Q        = 40,
	// Gap after a stop before the next start
	parameter int BUS_FREE = 1300
) (
	input  wire logic sda,
	output logic      scl,
	output logic      sda_rel
);
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// Steps are whole clocks, so a caller on a falling edge stays there
	task automatic start_cond();
		sda_rel = 1'b1;
		#Q scl = 1'b1;
		#Q sda_rel = 1'b0;
		#Q scl = 1'b0;
		#Q;
	endtask : start_cond
	task automatic stop_cond();
		sda_rel = 1'b0;
		#Q scl = 1'b1;
		#Q sda_rel = 1'b1;
		#(BUS_FREE);
	endtask : stop_cond
	task automatic bit_io(input logic b, output logic r);
		sda_rel = b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
		#Q;
	endtask : bit_io
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : wr_byte
	task automatic rd_byte(input logic ack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(!ack, r);
	endtask : rd_byte
endmodule : tsi_bus_master

// file: tb_top.sv
`timescale 1ns/1ps
`include "tsi_map.svh"
module tb_top;
	import tsi_pkg::*;
	localparam logic [6:0] DEV = {4'h9, 3'h5};
	logic clk = 1'b0;
	logic reset, scl, sda_rel, sda, sda_out, sda_oe_n, temp_valid, temp_ready;
	logic bus_busy, end_of_read_marker, reg_written, a;
	logic [15:0] temp_data, hyst, limit, ambient;
	logic [7:0]  cfg;
	logic [2:0]  strap = 3'h5;
	tsi_ptr_t    ptr;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int nak_seen = 0;
	int wr_seen = 0;
	// Pull-up: the line is low only while someone pulls it
	assign sda = sda_rel & (sda_oe_n | sda_out);
	tsi_bus_master m (.sda(sda), .scl(scl), .sda_rel(sda_rel));
	tsi_i2c_slave dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .addr_strap_bit2(strap[2]), .addr_strap_bit1(strap[1]),
		.addr_strap_bit0(strap[0]), .temp_valid(temp_valid), .temp_data(temp_data),
		.temp_ready(temp_ready), .reg_ptr(ptr), .config_reg(cfg),
		.hysteresis_limit_reg(hyst), .limit_set_reg(limit), .ambient_reg(ambient),
		.bus_busy(bus_busy), .end_of_read_marker(end_of_read_marker),
		.reg_written(reg_written));
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (end_of_read_marker === 1'b1) nak_seen <= nak_seen + 1;
		if (reg_written === 1'b1) wr_seen <= wr_seen + 1;
		if (cycles == 60000) begin
			num_errors++;
			test_done();
		end
	end
	task automatic compare(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : compare
	task automatic test_done();
		$display("checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done
	task automatic xfer_addr(input logic rd);
		m.start_cond();
		m.wr_byte({4'h9, strap, rd}, a);
		compare(a, 1'b1);
	endtask : xfer_addr
	task automatic wr_seq(input logic [23:0] b, input int n);
		xfer_addr(1'b0);
		for (int i = 0; i < n; i++) begin
			m.wr_byte(b[23-8*i -: 8], a);
			compare(a, 1'b1);
		end
		m.stop_cond();
	endtask : wr_seq
	task automatic rd_chk(input logic [7:0] e, input logic ack);
		logic [7:0] b;
		m.rd_byte(ack, b);
		compare(b, e);
	endtask : rd_chk
	task automatic s_reset();
		compare({sda_oe_n, bus_busy, temp_ready, ptr}, 5'h14);
		compare({cfg, hyst | limit | ambient}, 24'h0);
	endtask : s_reset
	task automatic s_writes();
		wr_seq(24'h021280, 3);
		compare(hyst, 16'h1280);
		compare(ptr, `TSI_PTR_HYST);
		wr_seq(24'h0355FF, 3);
		compare(limit, {8'h55, `TSI_LIMIT_LO_MASK});
		compare(ptr, `TSI_PTR_LIMIT);
		wr_seq(24'h01A500, 2);
		compare(cfg, 8'hA5);
		compare(wr_seen, 3);
	endtask : s_writes
	task automatic s_reads();
		repeat (2) begin
			xfer_addr(1'b1);
			rd_chk(8'hA5, 1'b0);
			m.stop_cond();
		end
		compare(nak_seen, 2);
		wr_seq(24'h020000, 1);
		compare(hyst, 16'h1280);
		xfer_addr(1'b1);
		rd_chk(8'h12, 1'b1);
		rd_chk(8'h80, 1'b1);
		rd_chk(8'h12, 1'b0);
		m.stop_cond();
		compare(nak_seen, 3);
	endtask : s_reads
	task automatic s_bad_addr();
		for (int i = 0; i < 7; i++) begin
			m.start_cond();
			m.wr_byte({DEV ^ (7'h01 << i), 1'b0}, a);
			compare(a, 1'b0);
			m.wr_byte(8'h01, a);
			compare(a, 1'b0);
			m.stop_cond();
		end
		compare(ptr, `TSI_PTR_HYST);
		// New strap levels move the address; the old one must be ignored
		strap = 3'h2;
		m.start_cond();
		m.wr_byte({DEV, 1'b1}, a);
		compare(a, 1'b0);
		m.stop_cond();
		xfer_addr(1'b1);
		rd_chk(8'h12, 1'b0);
		m.stop_cond();
		strap = 3'h5;
	endtask : s_bad_addr
	task automatic s_restart();
		xfer_addr(1'b0);
		repeat (3) m.bit_io(1'b0, a);
		xfer_addr(1'b1);
		rd_chk(8'h12, 1'b1);
		rd_chk(8'h80, 1'b0);
		m.stop_cond();
		compare(ptr, `TSI_PTR_HYST);
	endtask : s_restart
	task automatic s_ambient();
		wr_seq(24'h000000, 1);
		xfer_addr(1'b1);
		// Reading holds the queue, so it fills while the master pauses with the clock low
		// Sixteen words fit; the seventeenth is refused
		for (int i = 0; i < 17; i++) begin
			@(posedge clk);
			@(negedge clk);
			temp_data  = 16'hC100 + 16'(i);
			temp_valid = 1'b1;
		end
		@(posedge clk);
		@(negedge clk);
		compare(temp_ready, 1'b0);
		temp_valid = 1'b0;
		rd_chk(8'h00, 1'b1);
		rd_chk(8'h00, 1'b0);
		m.stop_cond();
		repeat (40) @(negedge clk);
		compare(ambient, 16'hC10F);
		compare(temp_ready, 1'b1);
		xfer_addr(1'b1);
		rd_chk(8'hC1, 1'b1);
		rd_chk(8'h0F, 1'b0);
		m.stop_cond();
	endtask : s_ambient
	initial begin
		reset = 1'b1;
		temp_valid = 1'b0;
		temp_data = 16'h0000;
		repeat (3) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		repeat (4) @(negedge clk);
		s_reset();
		s_writes();
		s_reads();
		s_bad_addr();
		s_restart();
		s_ambient();
		test_done();
	end
endmodule : tb_top
